// ---- core/pse_pkg.sv ----
// Constants, codes and carrier types of the power stage enable control
package pse_pkg;
    // Object sub-index of each drive data entry
    localparam logic [7:0]  SUB_ENABLE_SRC  = 8'h10;
    localparam logic [7:0]  SUB_SW_RATE     = 8'h30;
    localparam logic [7:0]  SUB_TEMP        = 8'h31;
    localparam logic [7:0]  SUB_TEMP_LIMIT  = 8'h32;
    localparam logic [7:0]  SUB_OVERMOD     = 8'h3A;
    // Enable source selector codes
    localparam logic [15:0] SRC_HW_ONLY     = 16'h0000;
    localparam logic [15:0] SRC_HW_PARAM    = 16'h0001;
    localparam logic [15:0] SRC_HW_CAN      = 16'h0002;
    localparam logic [15:0] SRC_HW_FB       = 16'h0003;
    localparam logic [15:0] SRC_HW_ETH      = 16'h0008;
    localparam logic [15:0] SRC_PARAM_ONLY  = 16'h0011;
    localparam logic [15:0] SRC_CAN_ONLY    = 16'h0012;
    localparam logic [15:0] SRC_FB_ONLY     = 16'h0013;
    localparam logic [15:0] SRC_ETH_ONLY    = 16'h0018;
    // Reset values
    localparam logic [15:0] RST_ENABLE_SRC  = 16'h0000;
    localparam logic [15:0] RST_SW_RATE     = 16'h0000;
    localparam logic [15:0] RST_OVERMOD     = 16'h0000;
    // Setting values of the two one-bit settings
    localparam logic [15:0] VAL_OFF         = 16'h0000;
    localparam logic [15:0] VAL_ON          = 16'h0001;
    // Operating mode codes on the mode input
    localparam logic [1:0]  MODE_POS        = 2'h0;
    localparam logic [1:0]  MODE_VEL        = 2'h1;
    localparam logic [1:0]  MODE_TRQ        = 2'h2;
    // Fieldbus kind codes
    localparam logic        KIND_CAN        = 1'b0;
    localparam logic        KIND_ETH        = 1'b1;
    // Speed below which the stage may be switched off, in rpm
    localparam logic [15:0] STOP_SPEED_RPM  = 16'h000A;
    // Default over-temperature limit in degrees Celsius
    localparam logic signed [15:0] TEMP_LIMIT_DEF = 16'sh0050;
    // Number of synchronised pin inputs
    localparam int          PIN_COUNT       = 4;

    // Bus or interface enable requests
    typedef struct packed {
        logic param_if;
        logic can;
        logic fieldbus;
        logic ethernet;
    } pse_src_t;

    // Object access request
    typedef struct packed {
        logic        req;
        logic        write;
        logic [7:0]  sub;
        logic [15:0] wdata;
    } pse_obj_req_t;

    // Output stage sequence
    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_RAMP,
        ST_BRAKE
    } pse_state_t;
endpackage : pse_pkg

// ---- core/pse_sync.sv ----
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pse_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;   // First stage, read only by second stage
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_dout;

    // Shift one stage per clock
    always_comb begin
        next_meta = din;
        next_dout = meta;
    end

    // Register both stages
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule : pse_sync

// ---- core/pse_ctrl.sv ----
// Power stage enable gating, shutdown sequencing and settings
// Overview of operation
// [RQ1] Stage enables only with hardware and controller enable
// [RQ2] Hardware enable gates transistor drive directly
// [RQ3] Speed modes ramp, stop below 10 rpm, brake
// [RQ4] Torque mode: immediate off with brake engage
// [RQ5] Fieldbus activation sets selector to 2 or 8
// [RQ6] Selector chooses which sources gate enabling
// [RQ7] Switching rate 0/1, changed only when off
// [RQ8] Overmodulation changed off, applied after store and reset
// [RQ9] Temperature readable; over limit trips with error
// [RQ10] Enable blocked until DC link charged, bypassed
// [RQ11] Temperature limit is fixed read-only signed value
// [RQ12] Enable is AND of all conditions
`timescale 1ns/100ps
module pse_ctrl #(
    parameter logic signed [15:0] TEMP_LIMIT = pse_pkg::TEMP_LIMIT_DEF  // Variant value
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    // Enable pins
    input  wire logic                  hw_enable_input,
    input  wire logic                  ctrl_enable_input,
    input  wire logic                  dc_link_charged,
    input  wire logic                  precharge_bypassed,
    // Bus and interface enables
    input  wire pse_pkg::pse_src_t     src_enable,
    input  wire logic                  fieldbus_on,
    input  wire logic                  fieldbus_kind,
    // Drive state
    input  wire logic [1:0]            op_mode,
    input  wire logic [15:0]           speed_abs_rpm,
    input  wire logic                  brake_fitted,
    input  wire logic                  brake_applied,
    input  wire logic signed [15:0]    bridge_temp,
    input  wire logic                  error_ack,
    input  wire logic                  nv_overmod,
    // Modulator drive
    input  wire logic [5:0]            pwm_in,
    output logic      [5:0]            gate_drive,
    // Stage control outputs
    output logic                       stage_on,
    output logic                       ramp_cmd,
    output logic                       brake_cmd,
    output logic                       ot_error,
    output logic                       pwm_half,
    output logic                       overmod_active,
    output logic                       overmod_stored,
    // Object access
    input  wire pse_pkg::pse_obj_req_t obj_in,
    output logic [15:0]                obj_rdata,
    output logic                       obj_ack,
    output logic                       obj_err
);
    import pse_pkg::*;

    logic [PIN_COUNT-1:0] pin_s;          // Synchronised pins
    logic                 hw_s;           // Hardware enable
    logic                 ctrl_s;         // Controller enable
    logic                 charged_s;      // DC link full
    logic                 bypass_s;       // Limiter bypassed
    logic                 src_ok;         // Selected source allows
    logic                 hard_ok;        // No immediate trip
    logic                 ready;          // Full enable condition
    logic                 over_temp;      // Temperature above limit
    pse_state_t           state;
    pse_state_t           next_state;
    logic                 next_stage_on;
    logic                 next_ramp_cmd;
    logic                 next_brake_cmd;
    logic [15:0]          enable_src;     // Selector register
    logic [15:0]          next_enable_src;
    logic                 sw_rate;        // Half frequency setting
    logic                 next_sw_rate;
    logic                 next_overmod_stored;
    logic                 next_overmod_active;
    logic                 init_done;      // Start-up capture done
    logic                 next_init_done;
    logic                 fb_on_d;        // Previous fieldbus level
    logic                 next_ot_error;
    logic [15:0]          next_obj_rdata;
    logic                 next_obj_ack;
    logic                 next_obj_err;

    // Pin synchronisers
    pse_sync #(
        .WIDTH (PIN_COUNT)
    ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .din     ({hw_enable_input, ctrl_enable_input, dc_link_charged, precharge_bypassed}),
        .dout    (pin_s)
    );
    assign hw_s      = pin_s[3];
    assign ctrl_s    = pin_s[2];
    assign charged_s = pin_s[1];
    assign bypass_s  = pin_s[0];

    // Source enable for a selector code
    function automatic logic src_allows(input logic [15:0] sel, input pse_src_t src);
        logic ok;
        ok = 1'b0;
        unique case (sel)
            SRC_HW_ONLY:                   ok = 1'b1;
            SRC_HW_PARAM, SRC_PARAM_ONLY:  ok = src.param_if;
            SRC_HW_CAN, SRC_CAN_ONLY:      ok = src.can;
            SRC_HW_FB, SRC_FB_ONLY:        ok = src.fieldbus;
            SRC_HW_ETH, SRC_ETH_ONLY:      ok = src.ethernet;
            default:                       ok = 1'b0;  // Unknown code never enables
        endcase
        return ok;
    endfunction : src_allows

    // Check that a code is a known selector
    function automatic logic src_known(input logic [15:0] sel);
        return (sel == SRC_HW_ONLY) || (sel == SRC_HW_PARAM) || (sel == SRC_HW_CAN) ||
               (sel == SRC_HW_FB) || (sel == SRC_HW_ETH) || (sel == SRC_PARAM_ONLY) ||
               (sel == SRC_CAN_ONLY) || (sel == SRC_FB_ONLY) || (sel == SRC_ETH_ONLY);
    endfunction : src_known

    // Enable conditions
    assign src_ok    = src_allows(enable_src, src_enable);                     // RQ6
    assign over_temp = bridge_temp > TEMP_LIMIT;                               // RQ11
    assign hard_ok   = hw_s && charged_s && bypass_s && !ot_error;             // RQ10
    assign ready     = hard_ok && ctrl_s && src_ok;                            // RQ1 RQ12

    // Transistor drive gated by hardware enable, not by sequencing alone
    assign gate_drive = pwm_in & {6{stage_on & hw_s}};                         // RQ2
    assign pwm_half   = sw_rate;

    // Stage sequence next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                // Switch on only when every condition holds
                if (ready) begin
                    next_state = ST_RUN;                                       // RQ1
                end
            end
            ST_RUN: begin
                if (!hard_ok) begin
                    next_state = ST_OFF;                                       // RQ9
                end else if (!ready) begin
                    // Torque mode stops at once, others ramp
                    if (op_mode == MODE_TRQ) begin
                        next_state = ST_OFF;                                   // RQ4
                    end else begin
                        next_state = ST_RAMP;                                  // RQ3
                    end
                end
            end
            ST_RAMP: begin
                if (!hard_ok) begin
                    next_state = ST_OFF;
                end else if (ready) begin
                    next_state = ST_RUN;
                end else if (speed_abs_rpm < STOP_SPEED_RPM) begin
                    next_state = ST_BRAKE;                                     // RQ3
                end
            end
            ST_BRAKE: begin
                // Wait for brake to close before removing torque
                if (!hard_ok || !brake_fitted || brake_applied) begin
                    next_state = ST_OFF;                                       // RQ3
                end
            end
        endcase
        next_stage_on  = (next_state != ST_OFF);
        next_ramp_cmd  = (next_state == ST_RAMP) || (next_state == ST_BRAKE);
        next_brake_cmd = (next_state == ST_OFF) || (next_state == ST_BRAKE);   // RQ4
    end

    // Stage sequence registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state     <= ST_OFF;
            stage_on  <= 1'b0;
            ramp_cmd  <= 1'b0;
            brake_cmd <= 1'b1;
        end else begin
            state     <= next_state;
            stage_on  <= next_stage_on;
            ramp_cmd  <= next_ramp_cmd;
            brake_cmd <= next_brake_cmd;
        end
    end

    // Settings, error latch and object access next values
    always_comb begin
        next_enable_src     = enable_src;
        next_sw_rate        = sw_rate;
        next_overmod_stored = overmod_stored;
        next_overmod_active = overmod_active;
        next_init_done      = 1'b1;
        next_obj_rdata      = obj_rdata;
        next_obj_ack        = 1'b0;
        next_obj_err        = 1'b0;
        // Applied value caught once after reset release
        if (!init_done) begin
            next_overmod_active = nv_overmod;                                  // RQ8
        end
        // Error cleared by acknowledge, a new trip wins
        next_ot_error = (ot_error && !error_ack) || over_temp;                 // RQ9
        // Object access answer
        if (obj_in.req) begin
            next_obj_ack = 1'b1;
            unique case (obj_in.sub)
                SUB_ENABLE_SRC: begin
                    next_obj_rdata = enable_src;
                    if (obj_in.write) begin
                        if (src_known(obj_in.wdata)) begin
                            next_enable_src = obj_in.wdata;                    // RQ6
                        end else begin
                            next_obj_err = 1'b1;
                        end
                    end
                end
                SUB_SW_RATE: begin
                    next_obj_rdata = {15'h0000, sw_rate};
                    if (obj_in.write) begin
                        // Locked while the stage runs
                        if (!stage_on && obj_in.wdata <= VAL_ON) begin
                            next_sw_rate = obj_in.wdata[0];                    // RQ7
                        end else begin
                            next_obj_err = 1'b1;                               // RQ7
                        end
                    end
                end
                SUB_OVERMOD: begin
                    next_obj_rdata = {15'h0000, overmod_stored};
                    if (obj_in.write) begin
                        if (!stage_on && obj_in.wdata <= VAL_ON) begin
                            next_overmod_stored = obj_in.wdata[0];             // RQ8
                        end else begin
                            next_obj_err = 1'b1;                               // RQ8
                        end
                    end
                end
                SUB_TEMP: begin
                    next_obj_rdata = bridge_temp;                              // RQ9
                    next_obj_err   = obj_in.write;
                end
                SUB_TEMP_LIMIT: begin
                    next_obj_rdata = TEMP_LIMIT;                               // RQ11
                    next_obj_err   = obj_in.write;
                end
                default: begin
                    next_obj_rdata = 16'h0000;
                    next_obj_err   = 1'b1;
                end
            endcase
        end
        // Bus activation forces the selector over any write
        if (fieldbus_on && !fb_on_d) begin
            next_enable_src = (fieldbus_kind == KIND_ETH) ? SRC_HW_ETH : SRC_HW_CAN; // RQ5
        end
    end

    // Settings, error latch and object access registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enable_src     <= RST_ENABLE_SRC;
            sw_rate        <= RST_SW_RATE[0];
            overmod_stored <= RST_OVERMOD[0];
            overmod_active <= RST_OVERMOD[0];
            init_done      <= 1'b0;
            fb_on_d        <= 1'b0;
            ot_error       <= 1'b0;
            obj_rdata      <= 16'h0000;
            obj_ack        <= 1'b0;
            obj_err        <= 1'b0;
        end else begin
            enable_src     <= next_enable_src;
            sw_rate        <= next_sw_rate;
            overmod_stored <= next_overmod_stored;
            overmod_active <= next_overmod_active;
            init_done      <= next_init_done;
            fb_on_d        <= fieldbus_on;
            ot_error       <= next_ot_error;
            obj_rdata      <= next_obj_rdata;
            obj_ack        <= next_obj_ack;
            obj_err        <= next_obj_err;
        end
    end

    // Checks
    stage_needs_enable_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ1
        $rose(stage_on) |-> $past(hw_s) && $past(ctrl_s) && $past(src_ok))
        else $error("stage switched on without enables");
    hw_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ2
        !hw_s |-> gate_drive == 6'h00)
        else $error("drive active without hardware enable");
    ramp_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ3
        state == ST_RAMP && hard_ok && !ready && speed_abs_rpm >= STOP_SPEED_RPM
        |=> stage_on && ramp_cmd)
        else $error("stage left ramp above stop speed");
    torque_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ4
        state == ST_RUN && op_mode == MODE_TRQ && !ready |=> !stage_on && brake_cmd)
        else $error("torque mode did not stop at once");
    bus_select_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ5
        $rose(fieldbus_on) && fieldbus_kind == KIND_CAN |=> enable_src == SRC_HW_CAN)
        else $error("selector not set on bus activation");
    source_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ6
        state == ST_OFF && !src_ok |=> !stage_on)
        else $error("unselected source enabled stage");
    rate_lock_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ7
        obj_in.req && obj_in.write && obj_in.sub == SUB_SW_RATE && stage_on
        |=> $stable(sw_rate) && obj_err)
        else $error("switching rate changed while running");
    overmod_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ8
        init_done |=> $stable(overmod_active))
        else $error("applied overmodulation changed without reset");
    temp_trip_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ9
        over_temp |=> ot_error ##1 !stage_on)
        else $error("over temperature did not trip");
    precharge_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ10
        !(charged_s && bypass_s) |=> !stage_on)
        else $error("stage on before DC link ready");
    enable_and_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ12
        state == ST_OFF && ready |=> stage_on && !brake_cmd)
        else $error("stage not enabled with all conditions met");
endmodule : pse_ctrl

// ---- test/pse_motor_model.sv ----
// Behavioural motor and holding brake on the far side of the stage control
`timescale 1ns/100ps
module pse_motor_model #(
    parameter logic [15:0] RUN_SPEED = 16'h0028  // Speed while driven
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Commands from the stage control
    input  wire logic        ramp_cmd,
    input  wire logic        brake_cmd,
    // Feedback to the stage control
    output logic      [15:0] speed_abs_rpm,
    output logic             brake_applied
);
    logic [1:0] brake_cnt;  // Slow brake, closes three cycles late

    // Speed falls by 2 rpm a cycle on the ramp; brake closes late
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            speed_abs_rpm <= RUN_SPEED;
            brake_cnt     <= 2'h0;
        end else begin
            if (!ramp_cmd) speed_abs_rpm <= RUN_SPEED;
            else if (speed_abs_rpm > 16'h0002) speed_abs_rpm <= speed_abs_rpm - 16'h0002;
            if (!brake_cmd) brake_cnt <= 2'h0;
            else if (brake_cnt != 2'h3) brake_cnt <= brake_cnt + 2'h1;
        end
    end

    // Closed feedback only once the delay has run out
    assign brake_applied = (brake_cnt == 2'h3);
endmodule : pse_motor_model

// ---- test/test_power_stage_enable_control.sv ----
// Self-checking bench of the power stage enable control
`timescale 1ns/100ps
module test_power_stage_enable_control;
    import pse_pkg::*;
    localparam logic signed [15:0] LIM = 16'sh0050;  // Limit set here
    logic               clk_sys = 1'b0;   // 100 MHz clock
    logic               resetn = 1'b0;    // Reset, active low
    logic [3:0]         pins = 4'h0;      // Hardware, controller, charged, bypassed
    pse_src_t           src = '0;         // Source enables
    logic               fb_on = 1'b0;     // Fieldbus active
    logic               fb_kind = 1'b0;   // Fieldbus kind
    logic [1:0]         mode = MODE_POS;  // Operating mode
    logic signed [15:0] temp = 16'sh0019; // Measured temperature
    logic               ack_err = 1'b0;   // Error acknowledge
    logic               nv_om = 1'b0;     // Saved overmodulation
    logic               fitted = 1'b1;    // Holding brake present
    logic [5:0]         pwm = 6'h2A;      // Modulator requests
    pse_obj_req_t       obj = '0;         // Object request
    logic [15:0]        spd, rd, obj_rdata;
    logic [5:0]         gate_drive;
    logic               brk_ok, stage_on, ramp_cmd, brake_cmd, ot_error;
    logic               pwm_half, om_act, om_st, obj_ack, obj_err;
    int                 mismatches = 0;
    int                 compares = 0;
    logic [15:0]        codes [9] = '{SRC_HW_ONLY, SRC_HW_PARAM, SRC_HW_CAN, SRC_HW_FB,
        SRC_HW_ETH, SRC_PARAM_ONLY, SRC_CAN_ONLY, SRC_FB_ONLY, SRC_ETH_ONLY};

    // Free-running clock
    always #5 clk_sys = ~clk_sys;

    pse_ctrl #(.TEMP_LIMIT(LIM)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
        .hw_enable_input(pins[3]), .ctrl_enable_input(pins[2]),
        .dc_link_charged(pins[1]), .precharge_bypassed(pins[0]), .src_enable(src),
        .fieldbus_on(fb_on), .fieldbus_kind(fb_kind), .op_mode(mode),
        .speed_abs_rpm(spd), .brake_fitted(fitted), .brake_applied(brk_ok),
        .bridge_temp(temp), .error_ack(ack_err), .nv_overmod(nv_om), .pwm_in(pwm),
        .gate_drive(gate_drive), .stage_on(stage_on), .ramp_cmd(ramp_cmd),
        .brake_cmd(brake_cmd), .ot_error(ot_error), .pwm_half(pwm_half),
        .overmod_active(om_act), .overmod_stored(om_st), .obj_in(obj),
        .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));

    pse_motor_model u_motor (.clk_sys(clk_sys), .resetn(resetn), .ramp_cmd(ramp_cmd),
        .brake_cmd(brake_cmd), .speed_abs_rpm(spd), .brake_applied(brk_ok));

    // Counts the verdict and ends the run
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // One comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One object access, answer checked in the cycle in which ack stands
    task automatic acc(input logic w, input logic [7:0] s, input logic [15:0] d,
                       input logic e);
        @(negedge clk_sys) obj = '{1'b1, w, s, d};
        @(negedge clk_sys) obj.req = 1'b0;
        chk(obj_ack, 1'b1);
        chk(obj_err, e);
        rd = obj_rdata;
    endtask : acc

    // Read and compare
    task automatic rdc(input logic [7:0] s, input logic [15:0] exp);
        acc(1'b0, s, 16'h0000, 1'b0);
        chk(rd, exp);
    endtask : rdc

    // Bounded wait for the stage state
    task automatic wt(input logic exp, input int n);
        int i;
        for (i = 0; i < n && stage_on !== exp; i++) @(negedge clk_sys);
        chk(stage_on, exp);
        if (stage_on !== exp) conclude();
    endtask : wt

    // Apply pins and see that the stage stays off
    task automatic off6(input logic [3:0] p);
        @(negedge clk_sys) pins = p;
        repeat (6) @(negedge clk_sys);
        chk(stage_on, 1'b0);
    endtask : off6

    // Reset values and read-only places
    task automatic t_reset;
        chk(brake_cmd, 1'b1);
        rdc(SUB_ENABLE_SRC, RST_ENABLE_SRC);
        rdc(SUB_SW_RATE, RST_SW_RATE);
        rdc(SUB_OVERMOD, RST_OVERMOD);
        rdc(SUB_TEMP, 16'h0019);
        acc(1'b1, SUB_TEMP_LIMIT, 16'h0064, 1'b1);
        rdc(SUB_TEMP_LIMIT, LIM);
        acc(1'b0, 8'h77, 16'h0000, 1'b1);
        $display("test reset done");
    endtask : t_reset

    // Both pins needed; hardware pin gates the transistors
    task automatic t_enable;
        off6(4'hB);
        off6(4'h7);
        @(negedge clk_sys) pins = 4'hF;
        wt(1'b1, 10);
        chk(gate_drive, pwm);
        @(negedge clk_sys) pins = 4'h7;
        wt(1'b0, 10);
        chk(gate_drive, 6'h00);
        $display("test enable done");
    endtask : t_enable

    // Torque mode off at once; speed mode ramps and waits for the brake
    task automatic t_stop;
        mode = MODE_TRQ;
        @(negedge clk_sys) pins = 4'hF;
        wt(1'b1, 10);
        @(negedge clk_sys) pins = 4'hB;
        wt(1'b0, 10);
        chk(brake_cmd, 1'b1);
        chk(ramp_cmd, 1'b0);
        mode = MODE_VEL;
        @(negedge clk_sys) pins = 4'hF;
        wt(1'b1, 10);
        @(negedge clk_sys) pins = 4'hB;
        repeat (4) @(negedge clk_sys);
        chk(ramp_cmd, 1'b1);
        chk(stage_on, 1'b1);
        wt(1'b0, 40);
        chk(16'(spd < STOP_SPEED_RPM), 16'h0001);
        chk(brk_ok, 1'b1);
        mode = MODE_POS;
        fitted = 1'b0;
        @(negedge clk_sys) pins = 4'hF;
        wt(1'b1, 10);
        @(negedge clk_sys) pins = 4'hB;
        wt(1'b0, 40);
        chk(16'(spd < STOP_SPEED_RPM), 16'h0001);
        fitted = 1'b1;
        $display("test stop done");
    endtask : t_stop

    // Rate setting only while off, 0 and 1 only
    task automatic t_rate;
        @(negedge clk_sys) pins = 4'hF;
        wt(1'b1, 10);
        acc(1'b1, SUB_SW_RATE, VAL_ON, 1'b1);
        chk(pwm_half, 1'b0);
        @(negedge clk_sys) pins = 4'h7;
        wt(1'b0, 10);
        acc(1'b1, SUB_SW_RATE, 16'h0002, 1'b1);
        acc(1'b1, SUB_SW_RATE, VAL_ON, 1'b0);
        chk(pwm_half, 1'b1);
        rdc(SUB_SW_RATE, VAL_ON);
        off6(4'hD);
        off6(4'hE);
        $display("test rate done");
    endtask : t_rate

    // Trip just above the limit, cleared by acknowledge
    task automatic t_temp;
        temp = LIM;
        @(negedge clk_sys) pins = 4'hF;
        wt(1'b1, 10);
        @(negedge clk_sys) temp = LIM + 16'sh0001;
        wt(1'b0, 5);
        chk(ot_error, 1'b1);
        rdc(SUB_TEMP, 16'h0051);
        temp = 16'sh0019;
        @(negedge clk_sys) ack_err = 1'b1;
        @(negedge clk_sys) ack_err = 1'b0;
        chk(ot_error, 1'b0);
        wt(1'b1, 10);
        @(negedge clk_sys) pins = 4'hD;
        wt(1'b0, 10);
        $display("test temperature done");
    endtask : t_temp

    // Fieldbus loads the selector; every code; bus-only gating
    task automatic t_src;
        @(negedge clk_sys) fb_on = 1'b1;
        rdc(SUB_ENABLE_SRC, SRC_HW_CAN);
        @(negedge clk_sys) fb_on = 1'b0;
        fb_kind = KIND_ETH;
        @(negedge clk_sys) fb_on = 1'b1;
        rdc(SUB_ENABLE_SRC, SRC_HW_ETH);
        foreach (codes[i]) begin
            acc(1'b1, SUB_ENABLE_SRC, codes[i], 1'b0);
            rdc(SUB_ENABLE_SRC, codes[i]);
        end
        acc(1'b1, SUB_ENABLE_SRC, 16'h0004, 1'b1);
        acc(1'b1, SUB_ENABLE_SRC, SRC_CAN_ONLY, 1'b0);
        off6(4'hF);
        src.can = 1'b1;
        wt(1'b1, 10);
        @(negedge clk_sys) pins = 4'h7;
        wt(1'b0, 10);
        $display("test source done");
    endtask : t_src

    // Overmodulation stored while off, applied after reset only
    task automatic t_om;
        acc(1'b1, SUB_OVERMOD, VAL_ON, 1'b0);
        chk(om_st, 1'b1);
        chk(om_act, 1'b0);
        @(negedge clk_sys) pins = 4'hF;
        wt(1'b1, 10);
        acc(1'b1, SUB_OVERMOD, VAL_OFF, 1'b1);
        chk(om_st, 1'b1);
        nv_om = 1'b1;
        @(negedge clk_sys) resetn = 1'b0;
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(om_act, 1'b1);
        rdc(SUB_ENABLE_SRC, SRC_HW_ETH);
        $display("test overmodulation done");
    endtask : t_om

    // Main sequence
    initial begin
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_enable();
        t_stop();
        t_rate();
        t_temp();
        t_src();
        t_om();
        conclude();
    end
endmodule : test_power_stage_enable_control
